// *** src/sas_pkg.sv ***
/*
 * shared constants of the smoke alarm sequencer: timing, register map,
 * field positions and reset values.
 * assumes a single 40 MHz core clock.
 */
package sas_pkg;
  // clock rate
  localparam int CLK_MHZ = 40;
  // nominal times in microseconds
  localparam int IDLE_PERIOD_US = 1650000;
  localparam int SMOKE_PERIOD_US = 41670;
  localparam int STROBE_US = 10000;
  localparam int LED_ON_US = 11600;
  localparam int HORN_PHASE_US = 500000;
  localparam int SMOKE_LED_US = 1000000;
  // derived cycle counts
  localparam int IDLE_PERIOD_CYC = IDLE_PERIOD_US * CLK_MHZ;
  localparam int SMOKE_PERIOD_CYC = SMOKE_PERIOD_US * CLK_MHZ;
  localparam int STROBE_CYC = STROBE_US * CLK_MHZ;
  localparam int LED_ON_CYC = LED_ON_US * CLK_MHZ;
  localparam int HORN_PHASE_CYC = HORN_PHASE_US * CLK_MHZ;
  localparam int SMOKE_LED_CYC = SMOKE_LED_US * CLK_MHZ;
  // time-base cycles between battery checks
  localparam logic [4:0] BATT_CYCLES = 5'h18;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] IRQ_CLR_OFS = 8'h0C;
  localparam logic [7:0] IRQ_EN_OFS = 8'h10;
  // control fields
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_TEST_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h1;
  // interrupt event bits
  localparam int EV_SMOKE_ON = 0;
  localparam int EV_SMOKE_OFF = 1;
  localparam int EV_BATT_LOW = 2;
  localparam int EV_W = 3;
  // operating modes
  typedef enum logic {SAS_CLEAR, SAS_ALARM} sas_mode_t;
endpackage

// *** src/sas_top.sv ***
/*
 * smoke alarm sequencer: time base, comparator strobing, led/battery
 * pulse, horn modulation and low-battery chirp, with an ahb-lite slave.
 * assumes comparator outputs and the test pin are asynchronous pins and
 * that a single ahb-lite master drives the bus with this slave alone.
 */
// Function
// - no smoke: time base of 1.65 s, one power strobe per period.
// - smoke sampled once a period, skipped in led pulse, chirp or horn-on.
// - low battery compared once every 24 time-base periods.
// - smoke switches the period to 41.67 ms and enables the horn driver.
// - in smoke the horn is gated 500 ms on, 500 ms off.
// - smoke resampled in each horn-off phase; none seen stops the horn.
// - smoke holds off the battery alarm; led pulses at 1 Hz.
// - a low test pin stops strobing; comparators stay powered.
// - test mode: status outputs follow the smoke and battery comparators.
// - each comparator power strobe lasts about 10 ms.
// - an 11.6 ms led pulse, a horn chirp instead once the battery is judged low, about every 40 s carries the battery check.
// - the sensitivity select is high while smoke is detected.
// - alarm ends only where the horn is off; no horn-on phase is cut.
`timescale 1ns/1ps
`default_nettype none
module sas_top
  import sas_pkg::*;
#(
  parameter int IdlePeriodCyc = IDLE_PERIOD_CYC,
  parameter int SmokePeriodCyc = SMOKE_PERIOD_CYC,
  parameter int StrobeCyc = STROBE_CYC,
  parameter int LedOnCyc = LED_ON_CYC,
  parameter int HornPhaseCyc = HORN_PHASE_CYC,
  parameter int SmokeLedCyc = SMOKE_LED_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // analog side pins
  input wire logic smokeCmpIn,
  input wire logic battLowCmpIn,
  input wire logic testMode_b,
  output logic cmpPowerOn,
  output logic ledOn,
  output logic hornOn,
  output logic sensHigh,
  output logic smokeStatus,
  output logic battStatus,
  // interrupt
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [2:0] syncA_q, syncB_q;
  logic smokeIn, battIn, testPin_b;

  // two flops per pin
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      syncA_q <= 3'h4;
      syncB_q <= 3'h4;
    end else begin
      syncA_q <= {testMode_b, battLowCmpIn, smokeCmpIn};
      syncB_q <= syncA_q;
    end
  end
  assign smokeIn = syncB_q[0];
  assign battIn = syncB_q[1];
  assign testPin_b = syncB_q[2];

  ////////////////////////////////////////////////////////////////////////
  // ahb-lite slave

  logic [1:0] ctrl_q, ctrl_d;
  logic [EV_W-1:0] irqStat_q, irqStat_d, irqEn_q, irqEn_d, events;
  logic wrPend_q, wrPend_d;
  logic [7:0] wrAddr_q, wrAddr_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] statWord;
  logic accept, testMode, run;

  assign accept = hsel && hready && htrans[1];
  assign run = ctrl_q[CTRL_RUN_BIT];
  assign testMode = !testPin_b || ctrl_q[CTRL_TEST_BIT];

  // decode, read data and write-back one cycle later
  always_comb begin
    ctrl_d = ctrl_q;
    irqEn_d = irqEn_q;
    wrPend_d = accept && hwrite;
    wrAddr_d = accept ? haddr[7:0] : wrAddr_q;
    rdata_d = 32'h0000_0000;
    irqStat_d = irqStat_q;
    if (wrPend_q) begin
      if (wrAddr_q == CTRL_OFS) begin
        ctrl_d = hwdata[1:0];
      end else if (wrAddr_q == IRQ_EN_OFS) begin
        irqEn_d = hwdata[EV_W-1:0];
      end else if (wrAddr_q == IRQ_CLR_OFS) begin
        irqStat_d = irqStat_q & ~hwdata[EV_W-1:0];
      end
    end
    irqStat_d = irqStat_d | events; // set wins over clear
    if (accept && !hwrite) begin
      if (haddr[7:0] == CTRL_OFS) begin
        rdata_d = {30'h0, ctrl_q};
      end else if (haddr[7:0] == STAT_OFS) begin
        rdata_d = statWord;
      end else if (haddr[7:0] == IRQ_STAT_OFS) begin
        rdata_d = {29'h0, irqStat_q};
      end else if (haddr[7:0] == IRQ_EN_OFS) begin
        rdata_d = {29'h0, irqEn_q};
      end
    end
  end

  // bus registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= CTRL_RST;
      irqEn_q <= 3'h0;
      irqStat_q <= 3'h0;
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      irq <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      irqEn_q <= irqEn_d;
      irqStat_q <= irqStat_d;
      wrPend_q <= wrPend_d;
      wrAddr_q <= wrAddr_d;
      rdata_q <= rdata_d;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      irq <= |(irqStat_d & irqEn_d);
    end
  end
  assign hrdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////
  // sequencer

  sas_mode_t mode_q, mode_d;
  logic [31:0] perCnt_q, perCnt_d, strCnt_q, strCnt_d;
  logic [31:0] pulCnt_q, pulCnt_d, phCnt_q, phCnt_d;
  logic [31:0] ledCnt_q, ledCnt_d;
  logic [4:0] cycCnt_q, cycCnt_d;
  logic hornPh_q, hornPh_d, chirp_q, chirp_d;
  logic battLow_q, battLow_d;
  logic cmpPow_d, led_d, horn_d, smkStat_d, batStat_d;
  logic tick, sample, busy;

  assign statWord = {27'h0, hornOn, ledOn, testMode, battLow_q,
                     mode_q == SAS_ALARM};

  // time base, strobes, pulses and horn gating
  always_comb begin
    mode_d = mode_q;
    perCnt_d = perCnt_q + 32'd1;
    strCnt_d = strCnt_q;
    pulCnt_d = pulCnt_q;
    phCnt_d = phCnt_q;
    ledCnt_d = ledCnt_q;
    cycCnt_d = cycCnt_q;
    hornPh_d = hornPh_q;
    chirp_d = chirp_q;
    battLow_d = battLow_q;
    events = '0;
    // period depends on mode
    tick = (mode_q == SAS_ALARM) ?
           (perCnt_q >= 32'(SmokePeriodCyc - 1)) :
           (perCnt_q >= 32'(IdlePeriodCyc - 1));
    if (tick || !run) begin
      perCnt_d = 32'h0;
    end
    // comparator power strobe per period
    if (tick && run) begin
      strCnt_d = 32'(StrobeCyc);
    end else if (strCnt_q != 32'h0) begin
      strCnt_d = strCnt_q - 32'd1;
    end
    // busy while led pulse, chirp or horn-on phase
    busy = (pulCnt_q != 32'h0) ||
           (mode_q == SAS_ALARM && hornPh_q);
    sample = (strCnt_q == 32'd1) && !busy;
    if (pulCnt_q != 32'h0) begin
      pulCnt_d = pulCnt_q - 32'd1;
    end
    if (mode_q == SAS_CLEAR) begin
      if (tick && run) begin
        cycCnt_d = (cycCnt_q == BATT_CYCLES - 5'h1) ? 5'h0 :
                   cycCnt_q + 5'h1;
        if (cycCnt_q == BATT_CYCLES - 5'h1) begin
          pulCnt_d = 32'(LedOnCyc);
          chirp_d = battLow_q;
        end
      end
      // battery judged at the end of the loaded pulse
      if (pulCnt_q == 32'd1) begin
        battLow_d = battIn;
        chirp_d = 1'b0;
        if (battIn && !battLow_q) begin
          events[EV_BATT_LOW] = 1'b1;
        end
      end
      if (sample && smokeIn) begin
        mode_d = SAS_ALARM;
        hornPh_d = 1'b1;
        phCnt_d = 32'h0;
        ledCnt_d = 32'h0;
        cycCnt_d = 5'h0;
        pulCnt_d = 32'h0;
        chirp_d = 1'b0;
        perCnt_d = 32'h0;
        events[EV_SMOKE_ON] = 1'b1;
      end
    end else begin
      // horn phases of equal length
      if (phCnt_q >= 32'(HornPhaseCyc - 1)) begin
        phCnt_d = 32'h0;
        hornPh_d = !hornPh_q;
      end else begin
        phCnt_d = phCnt_q + 32'd1;
      end
      // led at 1 hz
      if (ledCnt_q >= 32'(SmokeLedCyc - 1)) begin
        ledCnt_d = 32'h0;
      end else begin
        ledCnt_d = ledCnt_q + 32'd1;
      end
      chirp_d = 1'b0;
      // only horn-off samples can end the alarm
      if (sample && !smokeIn && !hornPh_q) begin
        mode_d = SAS_CLEAR;
        hornPh_d = 1'b0;
        perCnt_d = 32'h0;
        events[EV_SMOKE_OFF] = 1'b1;
      end
    end
    // output values
    cmpPow_d = (strCnt_d != 32'h0) || testMode;
    led_d = (mode_d == SAS_ALARM) ?
            (ledCnt_d < 32'(LedOnCyc)) :
            (pulCnt_d != 32'h0 && !chirp_d);
    horn_d = (mode_d == SAS_ALARM && hornPh_d) ||
             (pulCnt_d != 32'h0 && chirp_d);
    smkStat_d = testMode ? smokeIn : (mode_d == SAS_ALARM);
    batStat_d = testMode ? battIn : battLow_d;
  end

  // sequencer registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_q <= SAS_CLEAR;
      perCnt_q <= 32'h0;
      strCnt_q <= 32'h0;
      pulCnt_q <= 32'h0;
      phCnt_q <= 32'h0;
      ledCnt_q <= 32'h0;
      cycCnt_q <= 5'h0;
      hornPh_q <= 1'b0;
      chirp_q <= 1'b0;
      battLow_q <= 1'b0;
      cmpPowerOn <= 1'b0;
      ledOn <= 1'b0;
      hornOn <= 1'b0;
      sensHigh <= 1'b0;
      smokeStatus <= 1'b0;
      battStatus <= 1'b0;
    end else begin
      mode_q <= mode_d;
      perCnt_q <= perCnt_d;
      strCnt_q <= strCnt_d;
      pulCnt_q <= pulCnt_d;
      phCnt_q <= phCnt_d;
      ledCnt_q <= ledCnt_d;
      cycCnt_q <= cycCnt_d;
      hornPh_q <= hornPh_d;
      chirp_q <= chirp_d;
      battLow_q <= battLow_d;
      cmpPowerOn <= cmpPow_d;
      ledOn <= led_d;
      hornOn <= horn_d;
      sensHigh <= (mode_d == SAS_ALARM);
      smokeStatus <= smkStat_d;
      battStatus <= batStat_d;
    end
  end

endmodule
`default_nettype wire

// *** dv/sas_top_props.sv ***
/* assertions on the sequencer's pin side, bound into sas_top.
   assumes comparator and test pins come from a bench or model. */
`timescale 1ns/1ps
`default_nettype none
module sas_top_props #(
  parameter int IdlePeriodCyc = 200,
  parameter int StrobeCyc = 5,
  parameter int LedOnCyc = 6,
  parameter int HornPhaseCyc = 100
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // pins
  input wire logic smokeCmpIn,
  input wire logic battLowCmpIn,
  input wire logic testMode_b,
  input wire logic cmpPowerOn,
  input wire logic ledOn,
  input wire logic hornOn,
  input wire logic sensHigh,
  input wire logic smokeStatus,
  input wire logic battStatus
);
  int onCnt_q, hornCnt_q, ledCnt_q, gapCnt_q;
  logic pwrPrev_q, seen_q, skip_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // run lengths, and gap between strobe starts with alarm or test marked
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      {onCnt_q, hornCnt_q, ledCnt_q, gapCnt_q} <= '0;
      {pwrPrev_q, seen_q, skip_q} <= '0;
    end else begin
      onCnt_q <= cmpPowerOn ? onCnt_q + 1 : 0;
      hornCnt_q <= hornOn ? hornCnt_q + 1 : 0;
      ledCnt_q <= ledOn ? ledCnt_q + 1 : 0;
      pwrPrev_q <= cmpPowerOn;
      seen_q <= seen_q | (cmpPowerOn & !pwrPrev_q);
      gapCnt_q <= (cmpPowerOn && !pwrPrev_q) ? 1 : gapCnt_q + 1;
      skip_q <= ((cmpPowerOn && !pwrPrev_q) ? 1'b0 : skip_q) | sensHigh |
        !testMode_b;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  strobe_len_a: assert property (
    $fell(cmpPowerOn) && $past(testMode_b, 6) |-> onCnt_q == StrobeCyc)
    else $error("strobe length wrong");
  horn_start_a: assert property (
    $rose(sensHigh) |-> hornOn) else $error("horn not on at alarm");
  horn_phase_a: assert property (
    $fell(hornOn) |-> hornCnt_q == (sensHigh ? HornPhaseCyc : LedOnCyc))
    else $error("horn phase length wrong");
  alarm_end_a: assert property (
    $fell(sensHigh) |-> !hornOn && !$past(hornOn))
    else $error("alarm ended with horn on");
  led_len_a: assert property (
    $fell(ledOn) |-> ledCnt_q == LedOnCyc) else $error("led pulse wrong");
  idle_period_a: assert property (
    $rose(cmpPowerOn) && seen_q && !skip_q && !sensHigh && testMode_b
    |-> gapCnt_q == IdlePeriodCyc) else $error("idle period wrong");
  test_power_a: assert property (
    !testMode_b && !$past(testMode_b, 4) |-> cmpPowerOn)
    else $error("no power in test");
  test_follow_a: assert property (
    !testMode_b && !$past(testMode_b, 4) |-> smokeStatus ==
    $past(smokeCmpIn, 3) && battStatus == $past(battLowCmpIn, 3))
    else $error("test status not following");
  sens_state_a: assert property (
    testMode_b && $past(testMode_b, 4) |-> smokeStatus == sensHigh)
    else $error("sensitivity not with alarm");
endmodule
bind sas_top sas_top_props #(.IdlePeriodCyc(IdlePeriodCyc),
  .StrobeCyc(StrobeCyc), .LedOnCyc(LedOnCyc), .HornPhaseCyc(HornPhaseCyc))
  props_u (.core_clk, .rst_b, .smokeCmpIn, .battLowCmpIn, .testMode_b,
  .cmpPowerOn, .ledOn, .hornOn, .sensHigh, .smokeStatus, .battStatus);
`default_nettype wire

// *** dv/sas_chamber.sv ***
/* far-side model: smoke and battery comparators answering only while
   strobed. assumes the bench sets the analog levels. */
`timescale 1ns/1ps
`default_nettype none
module sas_chamber (
  // clock and power strobe
  input wire logic core_clk,
  input wire logic cmpPowerOn,
  // analog conditions
  input wire logic smokeLevel,
  input wire logic battLevel,
  // comparator outputs
  output logic smokeCmpIn = 1'b0,
  output logic battLowCmpIn = 1'b0
);
  // powered: follow levels; unpowered: outputs wander every cycle
  always @(posedge core_clk) begin
    smokeCmpIn <= cmpPowerOn ? smokeLevel : !smokeCmpIn;
    battLowCmpIn <= cmpPowerOn ? battLevel : !battLowCmpIn;
  end
endmodule
`default_nettype wire

// *** dv/test_smoke_alarm_sequencer.sv ***
/* bench for the smoke alarm sequencer: ahb-lite tasks and scenarios.
   assumes shortened counts and the comparator model. */
`timescale 1ns/1ps
`default_nettype none
module test_smoke_alarm_sequencer;
  import sas_pkg::*;
  logic core_clk, rst_b, hsel, hwrite, testMode_b, smokeLevel, battLevel;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, smokeCmpIn, battLowCmpIn, cmpPowerOn, ledOn;
  logic hornOn, sensHigh, smokeStatus, battStatus, irq;
  logic chirpSeen = 1'b0;
  logic ledSeen = 1'b0;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  // design with shortened counts
  sas_top #(.IdlePeriodCyc(200), .SmokePeriodCyc(20), .StrobeCyc(5),
    .LedOnCyc(6), .HornPhaseCyc(100), .SmokeLedCyc(40)) dut_u (.core_clk,
    .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .smokeCmpIn,
    .battLowCmpIn, .testMode_b, .cmpPowerOn, .ledOn, .hornOn, .sensHigh,
    .smokeStatus, .battStatus, .irq);
  sas_chamber far_u (.core_clk, .cmpPowerOn, .smokeLevel, .battLevel,
    .smokeCmpIn, .battLowCmpIn);
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task stop_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  // one single word transfer; read data lands in rd
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    hsize <= 3'h2;
    hwrite <= wr;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    hsize <= 3'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0, 32'(hresp));
  endtask
  task automatic waitchk(input string n, ref logic s, input logic v,
    input int lim);
    repeat (lim) if (s !== v) @(posedge core_clk);
    chk(n, 32'(v), 32'(s));
  endtask
  // chirp and alarm led watch; hang limit
  always @(posedge core_clk) begin
    cycles++;
    if (hornOn === 1'b1 && sensHigh === 1'b0) chirpSeen <= 1'b1;
    if (ledOn === 1'b1 && sensHigh === 1'b1) ledSeen <= 1'b1;
    if (cycles > 20000) begin
      miscompares++;
      stop_test;
    end
  end
  initial begin
    {rst_b, hwrite, htrans, haddr, hwdata, smokeLevel, battLevel} = '0;
    {hsel, hsize, testMode_b} = {1'b0, 3'h0, 1'b1};
    repeat (3) @(posedge core_clk);
    chk("outs", 32'h0, {25'h0, cmpPowerOn, ledOn, hornOn, sensHigh,
      smokeStatus, battStatus, irq});
    rst_b <= 1'b1;
    bus(1'b0, CTRL_OFS, 32'h0);
    chk("ctrl", 32'h1, rd);
    bus(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, rd);
    bus(1'b1, IRQ_EN_OFS, 32'h7);
    bus(1'b0, IRQ_EN_OFS, 32'h0);
    chk("irqen", 32'h7, rd);
    $display("test registers done");
    battLevel <= 1'b1;
    waitchk("battStatus", battStatus, 1'b1, 5200);
    bus(1'b0, IRQ_STAT_OFS, 32'h0);
    chk("irqstat", 32'h4, rd);
    chk("irq", 32'h1, 32'(irq));
    waitchk("chirp", chirpSeen, 1'b1, 5200);
    $display("test battery done");
    bus(1'b1, IRQ_CLR_OFS, 32'h7);
    smokeLevel <= 1'b1;
    waitchk("alarm", sensHigh, 1'b1, 250);
    chk("horn", 32'(hornOn), 32'h1);
    bus(1'b0, IRQ_STAT_OFS, 32'h0);
    chk("entered", 32'h1, rd & 32'h3);
    bus(1'b0, STAT_OFS, 32'h0);
    chk("status", 32'hB, rd & 32'hF);
    waitchk("alarmLed", ledSeen, 1'b1, 60);
    waitchk("hornOff", hornOn, 1'b0, 110);
    smokeLevel <= 1'b0;
    waitchk("cleared", sensHigh, 1'b0, 250);
    bus(1'b0, IRQ_STAT_OFS, 32'h0);
    chk("left", 32'h3, rd & 32'h3);
    bus(1'b1, IRQ_EN_OFS, 32'h0);
    repeat (2) @(posedge core_clk);
    chk("masked", 32'(irq), 32'h0);
    $display("test smoke done");
    {smokeLevel, battLevel, testMode_b} <= 3'h6;
    // unpowered comparators wander first, so wait out the sync path
    repeat (10) @(posedge core_clk);
    chk("tSmoke", 32'h1, 32'(smokeStatus));
    chk("tBatt1", 32'h1, 32'(battStatus));
    chk("tPower", 32'h1, 32'(cmpPowerOn));
    {smokeLevel, battLevel} <= 2'h0;
    waitchk("tBatt", battStatus, 1'b0, 10);
    chk("tSmoke0", 32'h0, 32'(smokeStatus));
    // software test keeps power once the pin lets go
    bus(1'b1, CTRL_OFS, 32'h3);
    testMode_b <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk("swPower", 32'h1, 32'(cmpPowerOn));
    bus(1'b0, STAT_OFS, 32'h0);
    chk("swTest", 32'h4, rd & 32'h4);
    testMode_b <= 1'b0;
    repeat (4) @(posedge core_clk);
    bus(1'b1, CTRL_OFS, 32'h1);
    testMode_b <= 1'b1;
    repeat (8) @(posedge core_clk);
    $display("test mode done");
    // run cleared: no strobe over more than one idle period
    bus(1'b1, CTRL_OFS, 32'h0);
    rd = 32'h0;
    repeat (250) begin
      @(posedge core_clk);
      rd = rd | 32'(cmpPowerOn);
    end
    chk("stopped", 32'h0, rd);
    $display("test run done");
    stop_test;
  end
endmodule
`default_nettype wire
